/* design/pml_pkg.sv */
// Purpose: Shared constants for the MII port, indicator and strap block.
// Assumes: Core clock of 125 MHz; MII link clock supplied from outside.
// Notes:   Every offset, field position and timing count lives here, as does the strap reset value.
package pml_pkg;

    // -------------------------------------------------------------------------
    // Vendor control word and indicator mode field
    // -------------------------------------------------------------------------
    localparam logic [4:0] VCTRL_ADDR      = 5'h1f;  // Address of vendor control word.
    localparam int         IND_MODE_LSB    = 4;      // Low bit of indicator mode field.
    localparam int         IND_MODE_MSB    = 5;      // High bit of indicator mode field.
    localparam logic [1:0] IND_MODE_LNKACT = 2'h0;   // Link plus blinking activity.
    localparam logic [1:0] IND_MODE_LINK   = 2'h1;   // Link state only.

    // -------------------------------------------------------------------------
    // Shared strap and output pins
    // -------------------------------------------------------------------------
    localparam int         STRAP_W   = 3;     // Number of shared strap/output pins.
    localparam int         PIN_COL   = 0;     // Collision output, config bit 0 strap.
    localparam int         PIN_CRS   = 1;     // Carrier sense output, config bit 1 strap.
    localparam int         PIN_IND   = 2;     // Indicator output, negotiation strap.
    localparam logic [2:0] STRAP_RST = 3'h0;  // Strap value held until sampled.

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CORE_CLK_KHZ  = 125000;  // Core clock rate in kHz.
    localparam int BLINK_HALF_MS = 50;      // Half period of activity blink in ms.
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CORE_CLK_KHZ;  // Cycles per half blink.

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    localparam int NIB_W = 4;  // MII nibble width.

    // Phase of the block after reset: straps are caught first, then pins drive.
    typedef enum logic {PML_PH_STRAP, PML_PH_RUN} pml_phase_e;

endpackage

/* design/pml_sync.sv */
// Purpose: Two flip-flop synchroniser for levels and toggles.
// Assumes: Input changes slowly compared with the destination clock.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ns
module pml_sync #(
    parameter int W = 1  // Number of independent bits.
) (
    input  wire logic         clk,     // Destination clock.
    input  wire logic         rst_b,   // Destination reset, active low.
    input  wire logic [W-1:0] d,       // Asynchronous input.
    output logic      [W-1:0] q        // Synchronised output.
);

    logic [W-1:0] meta_reg;  // First stage, may go metastable.

    // -------------------------------------------------------------------------
    // Two stages; each bit is crossed on its own.
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // pml_sync

/* design/pml_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock; both sides obey valid/ready handshaking.
// Notes:   Ready on the fill side comes straight from a flip-flop.
`timescale 1ns/1ns
module pml_buf2 #(
    parameter int W = 4  // Word width.
) (
    input  wire logic         clk,        // Clock.
    input  wire logic         rst_b,      // Reset, active low.
    input  wire logic [W-1:0] in_data,    // Word offered by the source.
    input  wire logic         in_valid,   // Source offers a word.
    output logic              in_ready,   // Buffer has room.
    output logic      [W-1:0] out_data,   // Oldest word held.
    output logic              out_valid,  // A word is held.
    input  wire logic         out_ready   // Drain takes the word.
);

    logic [W-1:0] mem_reg [2];  // The two entries.
    logic [W-1:0] mem_next [2];
    logic         wr_reg, wr_next;        // Write slot.
    logic         rd_reg, rd_next;        // Read slot.
    logic [1:0]   cnt_reg, cnt_next;      // Words held.
    logic         rdy_reg, rdy_next;      // Registered room flag.
    logic         push, pop;              // Accepted transfers.

    assign push      = in_valid && rdy_reg;
    assign pop       = out_ready && (cnt_reg != 2'h0);
    assign in_ready  = rdy_reg;
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rd_reg];

    // -------------------------------------------------------------------------
    // Next state: a word may enter and leave in the same cycle.
    // -------------------------------------------------------------------------
    always_comb
    begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (push)
        begin
            mem_next[wr_reg] = in_data;
            wr_next          = !wr_reg;
        end
        if (pop)
        begin
            rd_next = !rd_reg;
        end
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
        rdy_next = (cnt_next != 2'h2);
    end

    // Registers only.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_reg <= '{default: '0};
            wr_reg  <= 1'b0;
            rd_reg  <= 1'b0;
            cnt_reg <= 2'h0;
            rdy_reg <= 1'b1;
        end
        else
        begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
        end
    end

    // A full buffer never claims room, so no word is ever overwritten.
    a_buf_no_over : assert property (@(posedge clk) disable iff (!rst_b)
        (cnt_reg == 2'h2) |-> !in_ready)
        else $error("buffer shows room while full");

endmodule // pml_buf2

/* design/pml_mii_port.sv */
// Purpose: MII-side pin logic: indicator, low-power request, straps, nibble paths.
// Assumes: mii_clk comes from outside; link_up and mode come from core logic.
// Notes:   Receive nibbles cross to the link by a toggle handshake.
//
// Overview of operation
// - Mode field in bits 5:4 selects indicator.
// - Mode 01: link low, no link high only.
// - Transmit error high with transmit enable low requests low-power idle.
// - Without EEE, transmit error input is ignored.
// - Chip held in reset while reset low.
// - Receive nibbles valid only with receive valid.
// - Transmit nibbles taken only with transmit enable.
// - Strap pins sampled at reset release, then kept.
// - Shared pins are inputs in reset, outputs after.
`timescale 1ns/1ns
module pml_mii_port
    import pml_pkg::*;
#(
    parameter int BLINK_CYC = pml_pkg::BLINK_HALF_CYC  // Half blink period in cycles.
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        mii_clk,
    input  wire logic                        link_up,
    input  wire logic                        eee_enable,
    input  wire logic [15:0]                 vendor_ctrl_1f,
    input  wire logic [pml_pkg::NIB_W-1:0]   rx_in_data,
    input  wire logic                        rx_in_valid,
    output logic                             rx_in_ready,
    output logic      [pml_pkg::NIB_W-1:0]   tx_out_data,
    output logic                             tx_out_valid,
    output logic                             lpi_active,
    input  wire logic [pml_pkg::NIB_W-1:0]   mii_txd,
    input  wire logic                        mii_tx_en,
    input  wire logic                        mii_tx_er,
    output logic      [pml_pkg::NIB_W-1:0]   mii_rxd,
    output logic                             mii_rx_dv,
    input  wire logic [pml_pkg::STRAP_W-1:0] strap_pin_in,
    output logic      [pml_pkg::STRAP_W-1:0] strap_pin_out,
    output logic      [pml_pkg::STRAP_W-1:0] strap_pin_oe,
    output logic      [pml_pkg::STRAP_W-1:0] strap_cfg
);

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    localparam int BW = $clog2(BLINK_CYC + 1);  // Blink counter width.

    logic [1:0]         indicator_mode_field;  // Mode taken from the control word.
    logic               lrst_meta_reg;         // Link reset stage one.
    logic               lrst_b_reg;            // Link-domain reset, active low.
    logic [STRAP_W-1:0] spin_meta_reg;         // Strap pin stage one.
    logic [STRAP_W-1:0] spin_sync_reg;         // Strap pin stage two.
    pml_phase_e         phase_reg, phase_next; // Strap or run phase.
    logic [STRAP_W-1:0] cfg_reg, cfg_next;     // Caught strap levels.
    logic [STRAP_W-1:0] pout_reg, pout_next;   // Shared pin drive values.
    logic [STRAP_W-1:0] poe_reg, poe_next;     // Shared pin enables.
    logic [BW-1:0]      bcnt_reg, bcnt_next;   // Blink counter.
    logic               blink_reg, blink_next; // Blink phase.
    logic               lpi_reg, lpi_next;     // Low-power idle state.
    logic               activity;              // Transmit or receive in progress.
    // Receive handshake, core side.
    logic [NIB_W-1:0]   buf_data;
    logic               buf_valid, buf_take;
    logic [NIB_W-1:0]   hs_data_reg, hs_data_next;  // Nibble held for the link.
    logic               req_reg, req_next;          // Request toggle.
    logic               ack_sync;                   // Acknowledge toggle, synchronised.
    // Receive handshake, link side.
    logic               req_lsync, req_prev_reg;
    logic [NIB_W-1:0]   rxd_reg, rxd_next;
    logic               rxdv_reg, rxdv_next;
    logic               ack_reg, ack_next;
    // Transmit capture, link side.
    logic [NIB_W-1:0]   txn_reg, txn_next;     // Last nibble taken.
    logic               ttg_reg, ttg_next;     // Toggles per nibble.
    logic               ten_reg, lreq_reg;     // Enable and low-power request levels.
    // Transmit, core side.
    logic               ttg_csync, ttg_prev_reg, ten_csync, lreq_csync;
    logic [NIB_W-1:0]   txo_reg, txo_next;
    logic               txv_reg, txv_next;

    assign indicator_mode_field = vendor_ctrl_1f[IND_MODE_MSB:IND_MODE_LSB];

    // -------------------------------------------------------------------------
    // Link-domain reset: asserts at once, releases on mii_clk.
    // -------------------------------------------------------------------------
    always_ff @(posedge mii_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lrst_meta_reg <= 1'b0;
            lrst_b_reg    <= 1'b0;
        end
        else
        begin
            lrst_meta_reg <= 1'b1;
            lrst_b_reg    <= lrst_meta_reg;
        end
    end

    // Strap pins are synchronised without reset so that they carry the pin
    // level during reset; the level is then caught at the first edge after release.
    always_ff @(posedge core_clk)
    begin
        spin_meta_reg <= strap_pin_in;
        spin_sync_reg <= spin_meta_reg;
    end

    // -------------------------------------------------------------------------
    // Strap catch, shared pin drive and indicator.
    // -------------------------------------------------------------------------
    assign activity = ten_csync || buf_valid || rxdv_pending();

    function automatic logic rxdv_pending();
        return (req_reg != ack_sync);
    endfunction

    always_comb
    begin
        phase_next = phase_reg;
        cfg_next   = cfg_reg;
        pout_next  = pout_reg;
        poe_next   = poe_reg;
        bcnt_next  = bcnt_reg;
        blink_next = blink_reg;
        unique case (phase_reg)
            PML_PH_STRAP:
            begin
                // The first edge after release takes the strap levels once.
                cfg_next   = spin_sync_reg;
                phase_next = PML_PH_RUN;
            end
            PML_PH_RUN:
            begin
                poe_next = '1;
                // Blink counter runs only while traffic is seen.
                if (activity && (bcnt_reg == BW'(BLINK_CYC - 1)))
                begin
                    bcnt_next  = '0;
                    blink_next = !blink_reg;
                end
                else if (activity)
                begin
                    bcnt_next = bcnt_reg + BW'(1);
                end
                pout_next[PIN_COL] = ten_csync && buf_valid;
                pout_next[PIN_CRS] = activity;
                // Pin low lights the indicator.
                unique case (indicator_mode_field)
                    IND_MODE_LNKACT:
                        pout_next[PIN_IND] = !link_up || (activity && blink_reg);
                    IND_MODE_LINK:
                        pout_next[PIN_IND] = !link_up;
                    default:
                        pout_next[PIN_IND] = 1'b1;  // Reserved codes keep it dark.
                endcase
            end
        endcase
    end

    // Registers only; pins stay undriven through reset.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_reg <= PML_PH_STRAP;
            cfg_reg   <= STRAP_RST;
            pout_reg  <= '0;
            poe_reg   <= '0;
            bcnt_reg  <= '0;
            blink_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            cfg_reg   <= cfg_next;
            pout_reg  <= pout_next;
            poe_reg   <= poe_next;
            bcnt_reg  <= bcnt_next;
            blink_reg <= blink_next;
        end
    end

    assign strap_cfg     = cfg_reg;
    assign strap_pin_out = pout_reg;
    assign strap_pin_oe  = poe_reg;

    // -------------------------------------------------------------------------
    // Low-power idle request, taken only when EEE is in use.
    // -------------------------------------------------------------------------
    always_comb
    begin
        lpi_next = eee_enable && lreq_csync;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            lpi_reg <= 1'b0;
        else
            lpi_reg <= lpi_next;
    end

    assign lpi_active = lpi_reg;

    // -------------------------------------------------------------------------
    // Receive path: buffer, then toggle handshake to the link clock.
    // -------------------------------------------------------------------------
    pml_buf2 #(.W(NIB_W)) u_rx_buf (
        .clk       (core_clk),
        .rst_b     (rst_b),
        .in_data   (rx_in_data),
        .in_valid  (rx_in_valid),
        .in_ready  (rx_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_take)
    );

    pml_sync #(.W(1)) u_ack_sync (.clk(core_clk), .rst_b(rst_b), .d(ack_reg), .q(ack_sync));

    // A new nibble leaves only when the previous one is acknowledged, so the
    // held data are stable for the whole crossing.
    assign buf_take = buf_valid && (req_reg == ack_sync);

    always_comb
    begin
        hs_data_next = hs_data_reg;
        req_next     = req_reg;
        if (buf_take)
        begin
            hs_data_next = buf_data;
            req_next     = !req_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hs_data_reg <= '0;
            req_reg     <= 1'b0;
        end
        else
        begin
            hs_data_reg <= hs_data_next;
            req_reg     <= req_next;
        end
    end

    pml_sync #(.W(1)) u_req_sync (.clk(mii_clk), .rst_b(lrst_b_reg), .d(req_reg), .q(req_lsync));

    // Link side: a fresh request shows one nibble with receive valid for one cycle.
    always_comb
    begin
        rxd_next  = rxd_reg;
        rxdv_next = 1'b0;
        ack_next  = ack_reg;
        if (req_lsync != req_prev_reg)
        begin
            rxd_next  = hs_data_reg;
            rxdv_next = 1'b1;
            ack_next  = req_lsync;
        end
    end

    always_ff @(posedge mii_clk or negedge lrst_b_reg)
    begin
        if (!lrst_b_reg)
        begin
            req_prev_reg <= 1'b0;
            rxd_reg      <= '0;
            rxdv_reg     <= 1'b0;
            ack_reg      <= 1'b0;
        end
        else
        begin
            req_prev_reg <= req_lsync;
            rxd_reg      <= rxd_next;
            rxdv_reg     <= rxdv_next;
            ack_reg      <= ack_next;
        end
    end

    assign mii_rxd   = rxd_reg;
    assign mii_rx_dv = rxdv_reg;

    // -------------------------------------------------------------------------
    // Transmit path: nibbles taken on mii_clk while enable is high.
    // -------------------------------------------------------------------------
    always_comb
    begin
        txn_next = txn_reg;
        ttg_next = ttg_reg;
        if (mii_tx_en)
        begin
            txn_next = mii_txd;
            ttg_next = !ttg_reg;
        end
    end

    always_ff @(posedge mii_clk or negedge lrst_b_reg)
    begin
        if (!lrst_b_reg)
        begin
            txn_reg  <= '0;
            ttg_reg  <= 1'b0;
            ten_reg  <= 1'b0;
            lreq_reg <= 1'b0;
        end
        else
        begin
            txn_reg  <= txn_next;
            ttg_reg  <= ttg_next;
            ten_reg  <= mii_tx_en;
            lreq_reg <= mii_tx_er && !mii_tx_en;
        end
    end

    pml_sync #(.W(3)) u_tx_sync (
        .clk   (core_clk),
        .rst_b (rst_b),
        .d     ({ttg_reg, ten_reg, lreq_reg}),
        .q     ({ttg_csync, ten_csync, lreq_csync})
    );

    // The nibble register changes only one link period after its toggle, which
    // outlasts the two-stage toggle crossing at the core rate.
    always_comb
    begin
        txo_next = txo_reg;
        txv_next = (ttg_csync != ttg_prev_reg);
        if (ttg_csync != ttg_prev_reg)
            txo_next = txn_reg;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ttg_prev_reg <= 1'b0;
            txo_reg      <= '0;
            txv_reg      <= 1'b0;
        end
        else
        begin
            ttg_prev_reg <= ttg_csync;
            txo_reg      <= txo_next;
            txv_reg      <= txv_next;
        end
    end

    assign tx_out_data  = txo_reg;
    assign tx_out_valid = txv_reg;

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    a_mode_link_only : assert property (@(posedge core_clk) disable iff (!rst_b)
        (phase_reg == PML_PH_RUN && indicator_mode_field == IND_MODE_LINK)
        |=> (strap_pin_out[PIN_IND] == !$past(link_up)))
        else $error("indicator does not follow link in link-only mode");

    a_nolink_dark : assert property (@(posedge core_clk) disable iff (!rst_b)
        (phase_reg == PML_PH_RUN && indicator_mode_field == IND_MODE_LNKACT && !link_up)
        |=> strap_pin_out[PIN_IND])
        else $error("indicator lit without link");

    a_blink_toggle : assert property (@(posedge core_clk) disable iff (!rst_b)
        (activity && bcnt_reg == BW'(BLINK_CYC - 1)) |=> (blink_reg != $past(blink_reg)))
        else $error("blink phase missed its toggle");

    a_lpi_enter : assert property (@(posedge core_clk) disable iff (!rst_b)
        (eee_enable && lreq_csync) |=> lpi_active)
        else $error("low-power idle not entered on request");

    a_lpi_ignore : assert property (@(posedge core_clk) disable iff (!rst_b)
        !eee_enable |=> !lpi_active)
        else $error("transmit error acted on without EEE");

    a_strap_kept : assert property (@(posedge core_clk) disable iff (!rst_b)
        (phase_reg == PML_PH_RUN) |=> $stable(strap_cfg))
        else $error("strap configuration changed after capture");

    a_pins_release : assert property (@(posedge core_clk) disable iff (!rst_b)
        (phase_reg == PML_PH_STRAP) |-> (strap_pin_oe == '0) ##2 (strap_pin_oe == '1))
        else $error("shared pins not released to outputs after strap");

    a_rxdv_pulse : assert property (@(posedge mii_clk) disable iff (!lrst_b_reg)
        (mii_rx_dv && req_lsync == req_prev_reg) |=> !mii_rx_dv)
        else $error("receive valid held without a new nibble");

    a_tx_capture : assert property (@(posedge mii_clk) disable iff (!lrst_b_reg)
        mii_tx_en |=> (txn_reg == $past(mii_txd)) && (ttg_reg != $past(ttg_reg)))
        else $error("transmit nibble not taken with enable");

endmodule // pml_mii_port

/* testbench/pml_mac_model.sv */
// Purpose: MAC partner on the MII nibble pins.
// Assumes: The bench makes mii_clk.
// Notes:   Idle transmit data shows the inverse of the last nibble.
`timescale 1ns/1ns
module pml_mac_model
    import pml_pkg::*;
(
    input  wire logic                      mii_clk,
    input  wire logic [pml_pkg::NIB_W-1:0] mii_rxd,
    input  wire logic                      mii_rx_dv,
    output logic      [pml_pkg::NIB_W-1:0] mii_txd,
    output logic                           mii_tx_en,
    output logic                           mii_tx_er,
    output logic      [pml_pkg::NIB_W-1:0] rx_last,
    output int                             rx_cnt
);
    initial
    begin
        mii_txd   = 4'h0;
        mii_tx_en = 1'b0;
        mii_tx_er = 1'b0;
        rx_last   = 4'h0;
        rx_cnt    = 0;
    end
    // A nibble counts only in the link cycle that marks it valid.
    always @(posedge mii_clk)
    begin
        if (mii_rx_dv === 1'b1)
        begin
            rx_last <= mii_rxd;
            rx_cnt  <= rx_cnt + 1;
        end
    end
    // One nibble, with pins moved just after a link edge.
    task automatic send(input logic [3:0] n);
        @(posedge mii_clk);
        #1;
        mii_txd   = n;
        mii_tx_en = 1'b1;
        @(posedge mii_clk);
        #1;
        mii_tx_en = 1'b0;
        mii_txd   = ~n;
    endtask
    // Low-power request is error high while enable stays low.
    task automatic lpi(input logic r);
        @(posedge mii_clk);
        #1;
        mii_tx_er = r;
    endtask
endmodule // pml_mac_model

/* testbench/pml_mii_port_tb.sv */
// Purpose: Self-checking bench for the MII port block.
// Assumes: Blink count shortened to 8.
// Notes:   Core-side inputs change on the falling core edge; MII pins just after a link edge.
`timescale 1ns/1ns
module pml_mii_port_tb;
    import pml_pkg::*;
    logic        core_clk = 1'b0, mii_clk = 1'b0, rst_b = 1'b0, link_up = 1'b0;
    logic        eee_enable = 1'b0, rx_in_valid = 1'b0, rx_in_ready, tx_out_valid;
    logic        lpi_active, mii_tx_en, mii_tx_er, mii_rx_dv;
    logic [15:0] vendor_ctrl_1f = 16'h0000;
    logic [3:0]  rx_in_data = 4'h0, tx_out_data, mii_txd, mii_rxd, rx_last;
    logic [2:0]  strap_pull = 3'h5, strap_pin_in, strap_pin_out, strap_pin_oe, strap_cfg;
    int          rx_cnt, failures = 0, num_checks = 0;
    // The shared pin shows the pull until the block drives it.
    assign strap_pin_in = (strap_pin_oe & strap_pin_out) | (~strap_pin_oe & strap_pull);
    always #4 core_clk = ~core_clk;
    always #15 mii_clk = ~mii_clk;
    pml_mii_port #(.BLINK_CYC(8)) i_pml_mii_port (.core_clk, .rst_b, .mii_clk, .link_up,
        .eee_enable, .vendor_ctrl_1f, .rx_in_data, .rx_in_valid, .rx_in_ready, .tx_out_data,
        .tx_out_valid, .lpi_active, .mii_txd, .mii_tx_en, .mii_tx_er, .mii_rxd, .mii_rx_dv,
        .strap_pin_in, .strap_pin_out, .strap_pin_oe, .strap_cfg);
    pml_mac_model i_pml_mac_model (.mii_clk, .mii_rxd, .mii_rx_dv, .mii_txd, .mii_tx_en,
        .mii_tx_er, .rx_last, .rx_cnt);
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    // Flag picked by number: 0 room, 1 transmit valid, 2 low-power idle.
    function automatic logic flag(input int w);
        return (w == 0) ? rx_in_ready : ((w == 1) ? tx_out_valid : lpi_active);
    endfunction
    // Bounded wait on a flag; running out ends the run.
    task automatic await(input int w);
        int k;
        for (k = 0; k < 80 && flag(w) !== 1'b1; k++)
            @(negedge core_clk);
        chk({3'h0, flag(w)}, 4'h1);
        if (k == 80)
            end_sim();
    endtask
    task automatic push(input logic [3:0] n);
        @(negedge core_clk);
        rx_in_data  = n;
        rx_in_valid = 1'b1;
        await(0);
        @(negedge core_clk);
        rx_in_valid = 1'b0;
        rx_in_data  = ~n;
    endtask
    task automatic t_straps;
        repeat (20) @(negedge core_clk);
        chk({1'b0, strap_pin_oe}, 4'h0);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        chk({1'b0, strap_cfg}, 4'h5);
        chk({1'b0, strap_pin_oe}, 4'h7);
        strap_pull = 3'h2;
        repeat (4) @(negedge core_clk);
        chk({1'b0, strap_cfg}, 4'h5);
    endtask
    // Entries are mode, link, expected pin level.
    task automatic t_ind;
        logic [3:0] tbl [6] = '{4'h1, 4'h2, 4'h6, 4'h5, 4'hb, 4'hf};
        for (int i = 0; i < 6; i++)
        begin
            @(negedge core_clk);
            vendor_ctrl_1f = {10'h0, tbl[i][3:2], 4'h0};
            link_up        = tbl[i][1];
            repeat (2) @(negedge core_clk);
            chk({3'h0, strap_pin_out[PIN_IND]}, {3'h0, tbl[i][0]});
        end
    endtask
    // Mode 00 with link: the indicator must blink while receive words are pending.
    task automatic t_rx;
        int k;
        logic [1:0] seen = 2'h0;
        vendor_ctrl_1f = 16'h0000;
        link_up        = 1'b1;
        push(4'ha);
        push(4'h5);
        push(4'h3);
        chk({3'h0, strap_pin_out[PIN_CRS]}, 4'h1);
        chk({3'h0, strap_pin_out[PIN_COL]}, 4'h0);
        for (k = 0; k < 200 && rx_cnt < 3; k++)
        begin
            @(negedge core_clk);
            seen[strap_pin_out[PIN_IND]] = 1'b1;
        end
        chk({2'h0, seen}, 4'h3);
        chk(rx_cnt[3:0], 4'h3);
        chk(rx_last, 4'h3);
        if (k == 200)
            end_sim();
        repeat (5) @(negedge core_clk);
        chk({3'h0, strap_pin_out[PIN_CRS]}, 4'h0);
    endtask
    task automatic t_tx_lpi;
        i_pml_mac_model.send(4'hc);
        await(1);
        chk(tx_out_data, 4'hc);
        i_pml_mac_model.lpi(1'b1);
        repeat (12) @(negedge core_clk);
        chk({3'h0, lpi_active}, 4'h0);
        eee_enable = 1'b1;
        await(2);
        i_pml_mac_model.lpi(1'b0);
    endtask
    initial
    begin
        t_straps();
        t_ind();
        t_rx();
        t_tx_lpi();
        end_sim();
    end
endmodule // pml_mii_port_tb
